//--- rtl/pcm_client_port.sv
// mii client port: tx sink, marker pacing check, rx source
//
// What this block does
// [R1] tx word is 128 or 256 bits
// [R2] byte 7:0 and bit 0 leave first
// [R3] client freezes words while stalled plus one
// [R4] one control bit qualifies each byte lane
// [R5] fb fd 07 fe are control, rest data
// [R6] tx_pcs_ready high when tx pcs accepts
// [R7] client valid follows ready by fixed 1-10
// [R8] marker strobe held 5 or 2 valid cycles
// [R9] marker spacing 81915 or 32766 valid cycles
// [R10] simulation spacing 315 or 510 expected
// [R11] rx word 128 or 256, byte 0 first
// [R12] rx words invalid when not valid or marker
// [R13] rx valid qualifies data, control and marker
// [R14] rx_marker_seen flags received alignment marker
// [R15] client signals synchronous to one clock
// [R16] environment supplies reference clock
// [R17] clocks unreliable until every lock is high
// [R18] capture tx only when valid, no strobe
`timescale 1ns/10ps
module pcm_client_port #(
    parameter int LANES    = pcm_pkg::LANES_FOUR,
    parameter bit SIM_MODE = 1'b0,
    parameter int MARKER_SPACING =
        (LANES == pcm_pkg::LANES_FOUR) ?
        (SIM_MODE ? pcm_pkg::SPACING_SIM_FOUR
                  : pcm_pkg::SPACING_FOUR) :
        (SIM_MODE ? pcm_pkg::SPACING_SIM_TWO
                  : pcm_pkg::SPACING_TWO),
    parameter int DW = LANES * 64,
    parameter int CW = LANES * pcm_pkg::BYTES_PER_LANE,
    parameter int LW = LANES / 2
) (
    // [R15] every port below except pll_locked, which is synchronised, runs on core_clk
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    input  wire logic [LW-1:0]          pll_locked,
    input  wire logic                   tx_link_ready,
    input  wire logic [DW-1:0]          tx_word_data,
    input  wire logic [CW-1:0]          tx_word_ctrl,
    input  wire logic                   tx_word_valid,
    input  wire logic                   tx_marker_strobe,
    output logic                        tx_pcs_ready,
    output logic [DW-1:0]               tx_link_data,
    output logic [CW-1:0]               tx_link_ctrl,
    output logic                        tx_link_valid,
    output logic                        tx_marker_insert,
    input  wire logic [DW-1:0]          rx_link_data,
    input  wire logic [CW-1:0]          rx_link_ctrl,
    input  wire logic                   rx_link_valid,
    input  wire logic                   rx_link_marker,
    output logic [DW-1:0]               rx_word_data,
    output logic [CW-1:0]               rx_word_ctrl,
    output logic                        rx_word_valid,
    output logic                        rx_marker_seen,
    output logic                        rx_word_good,
    output pcm_pkg::pcm_status_type     status
);

    ////////////////////////////////////////////////////////////////
    // elaboration checks

    localparam int MARKER_LEN = (LANES == pcm_pkg::LANES_FOUR) ?
        pcm_pkg::MARKER_LEN_FOUR : pcm_pkg::MARKER_LEN_TWO;

    // [R1] only the two and four lane widths
    if (LANES != pcm_pkg::LANES_TWO &&
        LANES != pcm_pkg::LANES_FOUR) begin : g_bad_lanes
        $error("lanes must be 2 or 4");
    end
    if (DW != LANES * 64 || CW != DW / 8) begin : g_bad_width
        $error("word widths do not match lanes");
    end
    if (MARKER_SPACING < 1 ||
        MARKER_SPACING > 131071) begin : g_bad_spacing
        $error("marker spacing out of counter range");
    end

    localparam logic [16:0] SPACING_C = 17'(MARKER_SPACING);
    localparam logic [2:0]  LEN_C     = 3'(MARKER_LEN);

    ////////////////////////////////////////////////////////////////
    // pll lock synchroniser

    logic [LW-1:0] lock_s1_q;
    logic [LW-1:0] lock_s2_q;
    logic [LW-1:0] lock_s3_q;
    logic [LW-1:0] lock_q;
    logic [LW-1:0] lock_d;
    logic          clocks_ok;

    // a change is taken once the second and third stages agree
    assign lock_d = (lock_s2_q == lock_s3_q) ? lock_s3_q : lock_q;
    // [R17] usable only when every lock is high
    assign clocks_ok = &lock_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            lock_s1_q <= '0;
            lock_s2_q <= '0;
            lock_s3_q <= '0;
            lock_q    <= '0;
        end else begin
            lock_s1_q <= pll_locked;
            lock_s2_q <= lock_s1_q;
            lock_s3_q <= lock_s2_q;
            lock_q    <= lock_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // tx ready and capture

    logic tx_pcs_ready_d;
    logic tx_take;

    // [R6] ready only while clocks are trusted and the pcs can take
    assign tx_pcs_ready_d = clocks_ok & tx_link_ready;
    // [R18] frozen words are not taken
    assign tx_take = tx_word_valid & ~tx_marker_strobe;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_pcs_ready <= 1'b0;
        end else begin
            tx_pcs_ready <= tx_pcs_ready_d;
        end
    end

    // [R2] lanes pass in order, byte 7:0 and bit 0 go first
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_link_data  <= '0;
            tx_link_ctrl  <= '0;
            tx_link_valid <= 1'b0;
        end else begin
            tx_link_valid <= tx_take;
            if (tx_take) begin
                tx_link_data <= tx_word_data;
                tx_link_ctrl <= tx_word_ctrl;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // control byte checks per lane

    logic [CW-1:0] tx_bad_lane;
    logic [CW-1:0] rx_bad_lane;
    logic          rx_take;

    // [R12] rx words only count when valid and not a marker
    assign rx_take = rx_link_valid & ~rx_link_marker;

    // [R4] bit i of the control word judges byte i
    for (genvar i = 0; i < CW; i++) begin : g_lane
        // [R5] control bytes must be start, term, idle or error
        assign tx_bad_lane[i] = tx_take & tx_word_ctrl[i] &
            ~pcm_pkg::ctrl_legal(tx_word_data[8*i +: 8]);
        assign rx_bad_lane[i] = rx_take & rx_link_ctrl[i] &
            ~pcm_pkg::ctrl_legal(rx_link_data[8*i +: 8]);
    end

    ////////////////////////////////////////////////////////////////
    // marker strobe pacing

    logic [2:0]  run_q;
    logic [2:0]  run_d;
    logic [16:0] gap_q;
    logic [16:0] gap_d;
    logic        armed_q;
    logic        armed_d;
    logic        vs;
    logic        vn;
    logic        run_done;
    logic        short_err;
    logic        long_err;
    logic        gap_err;
    logic        insert_d;

    // [R8] only valid cycles count
    assign vs = tx_word_valid & tx_marker_strobe;
    assign vn = tx_word_valid & ~tx_marker_strobe;
    assign run_done = (run_q == LEN_C - 3'h1);

    // [R8] strobe held for exactly the marker length
    assign insert_d  = vs & run_done;
    assign short_err = vn & (run_q != 3'h0) & (run_q < LEN_C);
    assign long_err  = vs & (run_q == LEN_C);

    // [R9] [R10] gap since last strobe must match the spacing
    assign gap_err = vs & (run_q == 3'h0) & armed_q &
                     (gap_q != SPACING_C);

    assign run_d = vs ? ((run_q == LEN_C) ? run_q : run_q + 3'h1)
                 : (vn ? 3'h0 : run_q);
    assign gap_d = vs ? pcm_pkg::COUNT_RESET
                 : (vn & armed_q & (gap_q != 17'h1ffff))
                   ? gap_q + 17'h00001 : gap_q;
    assign armed_d = armed_q | insert_d;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            run_q            <= 3'h0;
            gap_q            <= pcm_pkg::COUNT_RESET;
            armed_q          <= 1'b0;
            tx_marker_insert <= 1'b0;
        end else begin
            run_q            <= run_d;
            gap_q            <= gap_d;
            armed_q          <= armed_d;
            tx_marker_insert <= insert_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // rx source

    // [R11] lanes pass in order, byte 7:0 was received first
    // [R13] valid, data, control and marker move together
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_word_data   <= '0;
            rx_word_ctrl   <= '0;
            rx_word_valid  <= 1'b0;
            rx_marker_seen <= 1'b0;
            rx_word_good   <= 1'b0;
        end else begin
            rx_word_data  <= rx_link_data;
            rx_word_ctrl  <= rx_link_ctrl;
            rx_word_valid <= rx_link_valid;
            // [R14] marker flag raised when a marker arrives
            rx_marker_seen <= rx_link_marker;
            // [R12] good only when valid and no marker
            rx_word_good   <= rx_take;
        end
    end

    ////////////////////////////////////////////////////////////////
    // status: fault bits sticky until reset, clocks_ok follows the lock

    pcm_pkg::pcm_status_type status_d;

    always_comb begin
        status_d = status;
        status_d.clocks_ok = clocks_ok;
        status_d.tx_marker_fault =
            status.tx_marker_fault | short_err | long_err;
        status_d.tx_spacing_fault =
            status.tx_spacing_fault | gap_err;
        status_d.tx_code_fault =
            status.tx_code_fault | (|tx_bad_lane);
        status_d.rx_code_fault =
            status.rx_code_fault | (|rx_bad_lane);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            status <= pcm_pkg::STATUS_RESET;
        end else begin
            status <= status_d;
        end
    end

endmodule // pcm_client_port

//--- rtl/pcm_pkg.sv
// constants and types for the mii client port
package pcm_pkg;

    // lane variants
    localparam int LANES_TWO  = 2;
    localparam int LANES_FOUR = 4;
    localparam int BYTES_PER_LANE = 8;

    // valid cycles a marker strobe is held
    localparam int MARKER_LEN_TWO  = 2;
    localparam int MARKER_LEN_FOUR = 5;

    // marker spacing in valid cycles
    localparam int SPACING_TWO      = 32766;
    localparam int SPACING_FOUR     = 81915;
    localparam int SPACING_SIM_TWO  = 510;
    localparam int SPACING_SIM_FOUR = 315;

    // mii control characters and the sfd data byte
    localparam logic [7:0] CHAR_START = 8'hfb;
    localparam logic [7:0] CHAR_TERM  = 8'hfd;
    localparam logic [7:0] CHAR_IDLE  = 8'h07;
    localparam logic [7:0] CHAR_ERROR = 8'hfe;
    localparam logic [7:0] CHAR_SFD   = 8'hd5;

    // reset values
    localparam logic [16:0] COUNT_RESET = 17'h00000;

    // status gathered for the user side, fault bits sticky
    typedef struct packed {
        logic clocks_ok;
        logic tx_marker_fault;
        logic tx_spacing_fault;
        logic tx_code_fault;
        logic rx_code_fault;
    } pcm_status_type;

    localparam pcm_status_type STATUS_RESET = '0;

    // a control byte must be one of the four control characters
    function automatic logic ctrl_legal(input logic [7:0] b);
        ctrl_legal = (b == CHAR_START) || (b == CHAR_TERM) ||
                     (b == CHAR_IDLE)  || (b == CHAR_ERROR);
    endfunction

endpackage

//--- bench/pcm_port_checker.sv
// assertions on the ports of the mii client port
`timescale 1ns/10ps
module pcm_port_checker #(
    parameter int LANES = 2,
    parameter int DW    = 128,
    parameter int LW    = 1
) (
    input wire logic                    core_clk,
    input wire logic                    rst,
    input wire logic [LW-1:0]           pll_locked,
    input wire logic [DW-1:0]           tx_word_data,
    input wire logic                    tx_word_valid,
    input wire logic                    tx_marker_strobe,
    input wire logic                    tx_pcs_ready,
    input wire logic [DW-1:0]           tx_link_data,
    input wire logic                    tx_link_valid,
    input wire logic                    tx_marker_insert,
    input wire logic                    rx_link_valid,
    input wire logic                    rx_link_marker,
    input wire logic                    rx_word_valid,
    input wire logic                    rx_marker_seen,
    input wire logic                    rx_word_good,
    input wire pcm_pkg::pcm_status_type status
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    tx_take_a: assert property (
        tx_word_valid && !tx_marker_strobe |=> tx_link_valid &&
        tx_link_data == $past(tx_word_data)) else $error("tx word lost");
    tx_idle_a: assert property (
        !(tx_word_valid && !tx_marker_strobe) |=> !tx_link_valid &&
        $stable(tx_link_data)) else $error("tx frozen word taken");
    rx_flag_a: assert property (
        1'b1 |=> rx_word_valid == $past(rx_link_valid) &&
        rx_marker_seen == $past(rx_link_marker)) else $error("rx flag off");
    rx_good_a: assert property (
        rx_word_good == (rx_word_valid && !rx_marker_seen))
        else $error("rx good wrong");
    rdy_lock_a: assert property (
        tx_pcs_ready |-> status.clocks_ok)
        else $error("ready without lock");
    lock_up_a: assert property (
        (&pll_locked)[*6] |-> status.clocks_ok) else $error("lock not seen");
    lock_dn_a: assert property (
        (!(&pll_locked))[*6] |-> !status.clocks_ok)
        else $error("lock loss not seen");
    ins_src_a: assert property (
        tx_marker_insert |-> $past(tx_word_valid && tx_marker_strobe))
        else $error("marker without strobe");
    ins_two_a: assert property (
        (LANES == 2 && tx_word_valid && !tx_marker_strobe) ##1
        (tx_word_valid && tx_marker_strobe)[*2] |=> tx_marker_insert)
        else $error("marker not inserted");
endmodule // pcm_port_checker

bind pcm_client_port pcm_port_checker #(.LANES(LANES), .DW(DW), .LW(LW))
    u_chk (.*);

//--- bench/pcm_client_model.sv
// client source model feeding the tx side of the port
`timescale 1ns/10ps
module pcm_client_model #(
    parameter int DLY = 3
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic         tx_pcs_ready,
    input  wire logic [127:0] nxt_data,
    input  wire logic [15:0]  nxt_ctrl,
    input  wire logic         nxt_strobe,
    output logic      [127:0] tx_word_data,
    output logic      [15:0]  tx_word_ctrl,
    output logic              tx_word_valid,
    output logic              tx_marker_strobe
);
    logic [DLY-1:0] rdy_q;

    // valid follows ready by fixed delay
    assign tx_word_valid = rdy_q[DLY-1];

    always_ff @(posedge core_clk) begin
        rdy_q <= rst ? '0 : {rdy_q[DLY-2:0], tx_pcs_ready};
        if (rst) tx_marker_strobe <= 1'b0;
        else if (tx_word_valid) tx_marker_strobe <= nxt_strobe;
        // words change only on reset or after a take
        if (rst || (tx_word_valid && !tx_marker_strobe)) begin
            tx_word_data <= nxt_data;
            tx_word_ctrl <= nxt_ctrl;
        end
    end
endmodule // pcm_client_model

//--- bench/pcm_client_port_tb_top.sv
// self-checking bench for the mii client port
`timescale 1ns/10ps
module pcm_client_port_tb_top;
    localparam int SP  = 20;
    localparam int DLY = 3;
    logic                    core_clk = 1'b0;
    logic                    rst = 1'b1;
    logic [0:0]              pll_locked = 1'b1;
    logic                    tx_link_ready = 1'b1;
    logic                    nxt_strobe = 1'b0;
    logic [127:0]            nxt_data = '0;
    logic [15:0]             nxt_ctrl = '0;
    logic [127:0]            rx_link_data = '0;
    logic [15:0]             rx_link_ctrl = '0;
    logic                    rx_link_valid = 1'b0;
    logic                    rx_link_marker = 1'b0;
    logic [127:0]            tx_word_data, tx_link_data, rx_word_data;
    logic [15:0]             tx_word_ctrl, tx_link_ctrl, rx_word_ctrl;
    logic                    tx_word_valid, tx_marker_strobe, tx_pcs_ready;
    logic                    tx_link_valid, tx_marker_insert, rx_word_valid;
    logic                    rx_marker_seen, rx_word_good;
    pcm_pkg::pcm_status_type status;
    int                      mismatches = 0;
    int                      compares = 0;
    int                      inserts = 0;

    // core_clk stands in for the derived clocks
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (tx_marker_insert === 1'b1) inserts <= inserts + 1;
    end

    pcm_client_port #(
        .LANES          (2),
        .SIM_MODE       (1'b1),
        .MARKER_SPACING (SP)
    ) DUT (.*);
    pcm_client_model #(.DLY(DLY)) u_client (.*);

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [127:0] e, got);
        compares++;
        if (got !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", nm, e, got);
        end
    endtask
    task automatic wrap_up();
        if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_tx();
        logic [127:0] w;
        w = {pcm_pkg::CHAR_TERM, pcm_pkg::CHAR_ERROR, 88'h0,
             pcm_pkg::CHAR_SFD, pcm_pkg::CHAR_IDLE, pcm_pkg::CHAR_START};
        @(posedge core_clk);
        nxt_data <= w;
        nxt_ctrl <= 16'hc003;
        step(4);
        chk("tx_data", w, tx_link_data);
        chk("tx_ctrl", 16'hc003, tx_link_ctrl);
        chk("tx_valid", 1, tx_link_valid);
        chk("tx_code", 0, status.tx_code_fault);
        @(posedge core_clk);
        nxt_data <= 128'h55;
        nxt_ctrl <= 16'h0001;
        step(5);
        chk("tx_code", 1, status.tx_code_fault);
    endtask
    task automatic t_stall();
        @(posedge core_clk);
        tx_link_ready <= 1'b0;
        repeat (DLY + 3) @(posedge core_clk);
        nxt_data <= 128'h1;
        step(4);
        chk("ready", 0, tx_pcs_ready);
        chk("tx_valid", 0, tx_link_valid);
        chk("tx_data", 128'h55, tx_link_data);
        @(posedge core_clk);
        tx_link_ready <= 1'b1;
        step(DLY + 5);
        chk("tx_data", 128'h1, tx_link_data);
    endtask
    task automatic t_rx();
        logic [7:0] cc [4] = '{pcm_pkg::CHAR_START, pcm_pkg::CHAR_TERM,
                               pcm_pkg::CHAR_IDLE, pcm_pkg::CHAR_ERROR};
        for (int i = 0; i < 7; i++) begin
            @(posedge core_clk);
            rx_link_data <= {(i < 4) ? cc[i] : 8'h00, 112'h0, 8'(i)};
            rx_link_ctrl <= 16'h8000;
            rx_link_valid <= (i != 4);
            rx_link_marker <= (i == 3 || i == 5);
            step(1);
            chk("rx_data", {(i < 4) ? cc[i] : 8'h00, 112'h0, 8'(i)},
                rx_word_data);
            chk("rx_valid", i != 4, rx_word_valid);
            chk("rx_marker", i == 3 || i == 5, rx_marker_seen);
            chk("rx_ctrl", 16'h8000, rx_word_ctrl);
            chk("rx_good", (i != 4 && i != 3 && i != 5), rx_word_good);
            chk("rx_code", i == 6, status.rx_code_fault);
        end
    endtask
    task automatic mark(input int g, input int n);
        repeat (g) @(posedge core_clk);
        nxt_strobe <= 1'b1;
        repeat (n) @(posedge core_clk);
        nxt_strobe <= 1'b0;
    endtask
    task automatic t_mark();
        mark(1, 2);
        mark(SP, 2);
        step(3);
        chk("inserts", 2, inserts);
        chk("spacing", 0, status.tx_spacing_fault);
        mark(SP - 2, 2);
        step(3);
        chk("spacing", 1, status.tx_spacing_fault);
        chk("marker", 0, status.tx_marker_fault);
        mark(SP, 1);
        step(3);
        chk("marker", 1, status.tx_marker_fault);
    endtask
    task automatic t_lock();
        @(posedge core_clk);
        pll_locked <= 1'b0;
        step(8);
        chk("lock", 0, status.clocks_ok);
        chk("ready", 0, tx_pcs_ready);
        @(posedge core_clk);
        pll_locked <= 1'b1;
        step(7);
        chk("ready", 1, tx_pcs_ready);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        step(DLY + 9);
        chk("ready", 1, tx_pcs_ready);
        t_tx();
        t_stall();
        t_rx();
        t_mark();
        t_lock();
        wrap_up();
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        mismatches++;
        wrap_up();
    end
endmodule // pcm_client_port_tb_top
